// File: ctrb_pkg.sv
package ctrb_pkg;

  // Register indices as printed; byte address is four times the index
  // because some printed offsets are not multiples of four.
  localparam logic [11:0] IDX_OFS_C1_P90_IN1 = 12'h348;
  localparam logic [11:0] IDX_OFS_C1_P90_IN2 = 12'h34A;
  localparam logic [11:0] IDX_OFS_C2_P0_IN1  = 12'h34C;
  localparam logic [11:0] IDX_OFS_C2_P0_IN2  = 12'h34E;
  localparam logic [11:0] IDX_BANK0_FINE_GAIN        = 12'h360;
  localparam logic [11:0] IDX_BANK1_FINE_GAIN        = 12'h361;
  localparam logic [11:0] IDX_BANK4_FINE_GAIN        = 12'h364;
  localparam logic [11:0] IDX_BANK5_FINE_GAIN        = 12'h365;
  localparam logic [11:0] IDX_CAL_CTRL       = 12'h370;
  localparam logic [11:0] IDX_TRIM_STATUS    = 12'h371;

  localparam int OFS_W      = 12;
  localparam int OFS_REG_W  = 16;
  localparam int GAIN_W     = 5;
  localparam int GAIN_REG_W = 8;
  localparam int NUM_OFS    = 4;
  localparam int NUM_GAIN   = 4;

  localparam logic [15:0] OFS_RESV_MASK  = 16'hF000;
  localparam logic [7:0]  GAIN_RESV_MASK = 8'hE0;
  localparam logic [0:0]  CAL_CTRL_RESET = 1'h0;

  typedef enum logic [1:0] {
    CTRB_OFS_C1_P90_IN1,
    CTRB_OFS_C1_P90_IN2,
    CTRB_OFS_C2_P0_IN1,
    CTRB_OFS_C2_P0_IN2
  } ctrb_ofs_sel_t;

  // Sampling context the datapath reports each cycle.
  typedef struct packed {
    logic core2;
    logic in2;
    logic ph90;
  } ctrb_ctx_t;

  // Factory trim image delivered by the fuse store.
  typedef struct packed {
    logic [NUM_OFS-1:0][OFS_REG_W-1:0]   ofs;
    logic [NUM_GAIN-1:0][GAIN_REG_W-1:0] gain;
  } ctrb_fuse_t;

  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } ctrb_wb_req_t;

endpackage

// File: ctrb_ofs_select.sv
`timescale 1ns/10ps
module ctrb_ofs_select (
  input  wire logic                                                 fg_cal_en,
  input  wire ctrb_pkg::ctrb_ctx_t                                   ctx,
  input  wire logic [ctrb_pkg::NUM_OFS-1:0][ctrb_pkg::OFS_REG_W-1:0] ofs,
  output logic      [ctrb_pkg::OFS_W-1:0]                            ofs_trim,
  output logic                                                      ofs_trim_valid
);

  always_comb begin
    ofs_trim       = '0;
    ofs_trim_valid = 1'b0;
    if (fg_cal_en) begin
      unique case ({ctx.core2, ctx.in2, ctx.ph90})
        3'b001: begin
          ofs_trim       = ofs[ctrb_pkg::CTRB_OFS_C1_P90_IN1][ctrb_pkg::OFS_W-1:0];
          ofs_trim_valid = 1'b1;
        end
        3'b011: begin
          ofs_trim       = ofs[ctrb_pkg::CTRB_OFS_C1_P90_IN2][ctrb_pkg::OFS_W-1:0];
          ofs_trim_valid = 1'b1;
        end
        3'b100: begin
          ofs_trim       = ofs[ctrb_pkg::CTRB_OFS_C2_P0_IN1][ctrb_pkg::OFS_W-1:0];
          ofs_trim_valid = 1'b1;
        end
        3'b110: begin
          ofs_trim       = ofs[ctrb_pkg::CTRB_OFS_C2_P0_IN2][ctrb_pkg::OFS_W-1:0];
          ofs_trim_valid = 1'b1;
        end
        default: begin
          ofs_trim       = '0;
          ofs_trim_valid = 1'b0;
        end
      endcase
    end
  end

endmodule

// File: ctrb_trim_bank.sv
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/10ps
// Functional notes
// - Core1 in1 ph90 uses its offset trim.
// - Core1 in2 ph90 uses its offset trim.
// - Core2 in1 ph0 uses its offset trim.
// - Core2 in2 ph0 uses its offset trim.
// - Offset trims default from fuse store.
// - Gain registers default from fuse, set gain.
// - Bank0 gain bits 4-0, 7-5 reserved RW.
// - Bank1 gain bits 4-0, applied to bank.
// - Bank4 gain bits 4-0, applied to bank.
// - Bank5 gain register adjusts bank5 gain.
// - Bank5 gain bits 4-0, 7-5 reserved.
module ctrb_trim_bank (
  input  wire logic                                  clk,
  input  wire logic                                  nrst,
  input  wire logic                                  fuse_valid,
  input  wire ctrb_pkg::ctrb_fuse_t                  fuse_data,
  input  wire ctrb_pkg::ctrb_ctx_t                   ctx,
  input  wire ctrb_pkg::ctrb_wb_req_t                wb_req,
  output logic      [31:0]                           wb_dat_o,
  output logic                                       wb_ack_o,
  output logic                                       wb_err_o,
  output logic      [ctrb_pkg::OFS_W-1:0]            ofs_trim,
  output logic                                       ofs_trim_valid,
  output logic      [ctrb_pkg::GAIN_W-1:0]           gain_bank0,
  output logic      [ctrb_pkg::GAIN_W-1:0]           gain_bank1,
  output logic      [ctrb_pkg::GAIN_W-1:0]           gain_bank4,
  output logic      [ctrb_pkg::GAIN_W-1:0]           gain_bank5,
  output logic                                       fg_cal_en
);

  typedef struct packed {
    logic [ctrb_pkg::NUM_OFS-1:0][ctrb_pkg::OFS_REG_W-1:0]   ofs;
    logic [ctrb_pkg::NUM_GAIN-1:0][ctrb_pkg::GAIN_REG_W-1:0] gain;
    logic                                                    cal_en;
    logic                                                    loaded;
    logic                                                    sw_wrote;
    logic [31:0]                                             rdata;
    logic                                                    ack;
    logic                                                    err;
  } ctrb_state_t;

  ctrb_state_t st_q;
  ctrb_state_t st_d;

  // Maps a register index to an offset slot; returns 1 when it hits one.
  function automatic logic ofs_hit(input logic [11:0] idx, output logic [1:0] slot);
    ofs_hit = 1'b1;
    slot    = 2'd0;
    unique case (idx)
      ctrb_pkg::IDX_OFS_C1_P90_IN1: slot = 2'd0;
      ctrb_pkg::IDX_OFS_C1_P90_IN2: slot = 2'd1;
      ctrb_pkg::IDX_OFS_C2_P0_IN1:  slot = 2'd2;
      ctrb_pkg::IDX_OFS_C2_P0_IN2:  slot = 2'd3;
      default:                      ofs_hit = 1'b0;
    endcase
  endfunction

  function automatic logic gain_hit(input logic [11:0] idx, output logic [1:0] slot);
    gain_hit = 1'b1;
    slot     = 2'd0;
    unique case (idx)
      ctrb_pkg::IDX_BANK0_FINE_GAIN: slot = 2'd0;
      ctrb_pkg::IDX_BANK1_FINE_GAIN: slot = 2'd1;
      ctrb_pkg::IDX_BANK4_FINE_GAIN: slot = 2'd2;
      ctrb_pkg::IDX_BANK5_FINE_GAIN: slot = 2'd3;
      default:               gain_hit = 1'b0;
    endcase
  endfunction

  // Byte-lane merge of a write into an existing 32-bit word.
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    merge = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merge[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
  endfunction

  logic [11:0] idx;
  logic        req;
  logic        oh;
  logic        gh;
  logic [1:0]  os;
  logic [1:0]  gs;
  logic [31:0] wv;

  assign idx = wb_req.adr[13:2];
  assign req = wb_req.cyc & wb_req.stb & ~st_q.ack & ~st_q.err;

  always_comb begin
    st_d       = st_q;
    st_d.ack   = 1'b0;
    st_d.err   = 1'b0;
    oh         = ofs_hit(idx, os);
    gh         = gain_hit(idx, gs);
    wv         = 32'h0000_0000;
    // Fuse image loads once after reset, unless software already wrote.
    if (fuse_valid && !st_q.loaded) begin
      st_d.loaded = 1'b1;
      if (!st_q.sw_wrote) begin
        st_d.ofs  = fuse_data.ofs;
        st_d.gain = fuse_data.gain;
      end
    end
    if (req) begin
      if (oh || gh || idx == ctrb_pkg::IDX_CAL_CTRL || idx == ctrb_pkg::IDX_TRIM_STATUS) begin
        st_d.ack = 1'b1;
      end else begin
        st_d.err = 1'b1;
      end
      st_d.rdata = 32'h0000_0000;
      if (oh) begin
        st_d.rdata = {16'h0000, st_q.ofs[os]};
      end else if (gh) begin
        st_d.rdata = {24'h00_0000, st_q.gain[gs]};
      end else if (idx == ctrb_pkg::IDX_CAL_CTRL) begin
        st_d.rdata = {31'h0000_0000, st_q.cal_en};
      end else if (idx == ctrb_pkg::IDX_TRIM_STATUS) begin
        st_d.rdata = {28'h000_0000, ofs_trim_valid, st_q.sw_wrote, st_q.loaded, fuse_valid};
      end
      if (wb_req.we) begin
        if (oh) begin
          wv              = merge({16'h0000, st_q.ofs[os]}, wb_req.dat, wb_req.sel);
          st_d.ofs[os]    = wv[15:0];
          st_d.sw_wrote   = 1'b1;
        end else if (gh) begin
          wv              = merge({24'h00_0000, st_q.gain[gs]}, wb_req.dat, wb_req.sel);
          st_d.gain[gs]   = wv[7:0];
          st_d.sw_wrote   = 1'b1;
        end else if (idx == ctrb_pkg::IDX_CAL_CTRL && wb_req.sel[0]) begin
          st_d.cal_en     = wb_req.dat[0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q          <= '0;
      st_q.cal_en   <= ctrb_pkg::CAL_CTRL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_dat_o   = st_q.rdata;
  assign wb_ack_o   = st_q.ack;
  assign wb_err_o   = st_q.err;
  assign fg_cal_en  = st_q.cal_en;
  assign gain_bank0 = st_q.gain[0][ctrb_pkg::GAIN_W-1:0];
  assign gain_bank1 = st_q.gain[1][ctrb_pkg::GAIN_W-1:0];
  assign gain_bank4 = st_q.gain[2][ctrb_pkg::GAIN_W-1:0];
  assign gain_bank5 = st_q.gain[3][ctrb_pkg::GAIN_W-1:0];

  ctrb_ofs_select u_sel (
    .fg_cal_en      (st_q.cal_en),
    .ctx            (ctx),
    .ofs            (st_q.ofs),
    .ofs_trim       (ofs_trim),
    .ofs_trim_valid (ofs_trim_valid)
  );

  a_ofs_gate: assert property (@(posedge clk) disable iff (!nrst)
    !st_q.cal_en |-> !ofs_trim_valid)
    else $error("offset trim active with calibration off");

  a_ofs_core1_in1: assert property (@(posedge clk) disable iff (!nrst)
    st_q.cal_en && ctx == 3'b001 |-> ofs_trim == st_q.ofs[0][11:0] && ofs_trim_valid)
    else $error("core1 in1 ph90 offset wrong");

  a_ofs_core1_in2: assert property (@(posedge clk) disable iff (!nrst)
    st_q.cal_en && ctx == 3'b011 |-> ofs_trim == st_q.ofs[1][11:0] && ofs_trim_valid)
    else $error("core1 in2 ph90 offset wrong");

  a_ofs_core2_in1: assert property (@(posedge clk) disable iff (!nrst)
    st_q.cal_en && ctx == 3'b100 |-> ofs_trim == st_q.ofs[2][11:0] && ofs_trim_valid)
    else $error("core2 in1 ph0 offset wrong");

  a_ofs_core2_in2: assert property (@(posedge clk) disable iff (!nrst)
    st_q.cal_en && ctx == 3'b110 |-> ofs_trim == st_q.ofs[3][11:0] && ofs_trim_valid)
    else $error("core2 in2 ph0 offset wrong");

  a_fuse_ofs_load: assert property (@(posedge clk) disable iff (!nrst)
    fuse_valid && !st_q.loaded && !st_q.sw_wrote && !req |=> st_q.ofs == $past(fuse_data.ofs))
    else $error("offset trims not loaded from fuse");

  a_fuse_gain_load: assert property (@(posedge clk) disable iff (!nrst)
    fuse_valid && !st_q.loaded && !st_q.sw_wrote && !req |=> st_q.gain == $past(fuse_data.gain))
    else $error("gains not loaded from fuse");

  a_gain0_write: assert property (@(posedge clk) disable iff (!nrst)
    req && wb_req.we && idx == ctrb_pkg::IDX_BANK0_FINE_GAIN && wb_req.sel[0]
    |=> st_q.gain[0] == $past(wb_req.dat[7:0]) && gain_bank0 == $past(wb_req.dat[4:0]))
    else $error("bank0 gain write lost");

  a_gain1_write: assert property (@(posedge clk) disable iff (!nrst)
    req && wb_req.we && idx == ctrb_pkg::IDX_BANK1_FINE_GAIN && wb_req.sel[0]
    |=> gain_bank1 == $past(wb_req.dat[4:0]))
    else $error("bank1 gain write lost");

  a_gain4_write: assert property (@(posedge clk) disable iff (!nrst)
    req && wb_req.we && idx == ctrb_pkg::IDX_BANK4_FINE_GAIN && wb_req.sel[0]
    |=> gain_bank4 == $past(wb_req.dat[4:0]))
    else $error("bank4 gain write lost");

  a_gain5_write: assert property (@(posedge clk) disable iff (!nrst)
    req && wb_req.we && idx == ctrb_pkg::IDX_BANK5_FINE_GAIN && wb_req.sel[0]
    |=> gain_bank5 == $past(wb_req.dat[4:0]) ##1 !wb_ack_o)
    else $error("bank5 gain write lost");

  // A trim that does not apply must read as zero so the datapath adds nothing.
  a_ofs_idle_zero: assert property (@(posedge clk) disable iff (!nrst)
    !ofs_trim_valid
    |-> ofs_trim == 12'h000)
    else $error("inactive offset trim not zero");

  a_ofs_ctx_miss: assert property (@(posedge clk) disable iff (!nrst)
    ctx.core2 == ctx.ph90
    |-> !ofs_trim_valid)
    else $error("offset trim active for unmapped context");

  a_cal_off_trim: assert property (@(posedge clk) disable iff (!nrst)
    !fg_cal_en
    |-> ofs_trim == 12'h000)
    else $error("offset trim nonzero with calibration off");

  // A full-width write must land in the slot that the context decode uses.
  a_ofs_wr_c1i1: assert property (@(posedge clk) disable iff (!nrst)
    req && wb_req.we && idx == ctrb_pkg::IDX_OFS_C1_P90_IN1 && wb_req.sel[1:0] == 2'h3
    |=> st_q.ofs[0] == $past(wb_req.dat[15:0]))
    else $error("core1 in1 ph90 offset write lost");

  a_ofs_wr_c1i2: assert property (@(posedge clk) disable iff (!nrst)
    req && wb_req.we && idx == ctrb_pkg::IDX_OFS_C1_P90_IN2 && wb_req.sel[1:0] == 2'h3
    |=> st_q.ofs[1] == $past(wb_req.dat[15:0]))
    else $error("core1 in2 ph90 offset write lost");

  a_ofs_wr_c2i1: assert property (@(posedge clk) disable iff (!nrst)
    req && wb_req.we && idx == ctrb_pkg::IDX_OFS_C2_P0_IN1 && wb_req.sel[1:0] == 2'h3
    |=> st_q.ofs[2] == $past(wb_req.dat[15:0]))
    else $error("core2 in1 ph0 offset write lost");

  a_ofs_wr_c2i2: assert property (@(posedge clk) disable iff (!nrst)
    req && wb_req.we && idx == ctrb_pkg::IDX_OFS_C2_P0_IN2 && wb_req.sel[1:0] == 2'h3
    |=> st_q.ofs[3] == $past(wb_req.dat[15:0]))
    else $error("core2 in2 ph0 offset write lost");

  // Reads return the stored word, reserved bits included, with the ack.
  a_ofs_rd_c1i1: assert property (@(posedge clk) disable iff (!nrst)
    req && !wb_req.we && idx == ctrb_pkg::IDX_OFS_C1_P90_IN1
    |=> wb_ack_o && wb_dat_o == {16'h0000, $past(st_q.ofs[0])})
    else $error("core1 in1 ph90 offset read wrong");

  a_ofs_rd_c1i2: assert property (@(posedge clk) disable iff (!nrst)
    req && !wb_req.we && idx == ctrb_pkg::IDX_OFS_C1_P90_IN2
    |=> wb_ack_o && wb_dat_o == {16'h0000, $past(st_q.ofs[1])})
    else $error("core1 in2 ph90 offset read wrong");

  a_ofs_rd_c2i1: assert property (@(posedge clk) disable iff (!nrst)
    req && !wb_req.we && idx == ctrb_pkg::IDX_OFS_C2_P0_IN1
    |=> wb_ack_o && wb_dat_o == {16'h0000, $past(st_q.ofs[2])})
    else $error("core2 in1 ph0 offset read wrong");

  a_ofs_rd_c2i2: assert property (@(posedge clk) disable iff (!nrst)
    req && !wb_req.we && idx == ctrb_pkg::IDX_OFS_C2_P0_IN2
    |=> wb_ack_o && wb_dat_o == {16'h0000, $past(st_q.ofs[3])})
    else $error("core2 in2 ph0 offset read wrong");

  a_gain_rd_b0: assert property (@(posedge clk) disable iff (!nrst)
    req && !wb_req.we && idx == ctrb_pkg::IDX_BANK0_FINE_GAIN
    |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(st_q.gain[0])})
    else $error("bank0 gain read wrong");

  a_gain_rd_b1: assert property (@(posedge clk) disable iff (!nrst)
    req && !wb_req.we && idx == ctrb_pkg::IDX_BANK1_FINE_GAIN
    |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(st_q.gain[1])})
    else $error("bank1 gain read wrong");

  a_gain_rd_b4: assert property (@(posedge clk) disable iff (!nrst)
    req && !wb_req.we && idx == ctrb_pkg::IDX_BANK4_FINE_GAIN
    |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(st_q.gain[2])})
    else $error("bank4 gain read wrong");

  a_gain_rd_b5: assert property (@(posedge clk) disable iff (!nrst)
    req && !wb_req.we && idx == ctrb_pkg::IDX_BANK5_FINE_GAIN
    |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(st_q.gain[3])})
    else $error("bank5 gain read wrong");

  // Reserved gain bits are plain storage and must survive a write.
  a_gain_resv_b0: assert property (@(posedge clk) disable iff (!nrst)
    req && wb_req.we && idx == ctrb_pkg::IDX_BANK0_FINE_GAIN && wb_req.sel[0]
    |=> st_q.gain[0][7:5] == $past(wb_req.dat[7:5]))
    else $error("bank0 reserved bits not stored");

  a_gain_resv_b5: assert property (@(posedge clk) disable iff (!nrst)
    req && wb_req.we && idx == ctrb_pkg::IDX_BANK5_FINE_GAIN && wb_req.sel[0]
    |=> st_q.gain[3][7:5] == $past(wb_req.dat[7:5]))
    else $error("bank5 reserved bits not stored");

  // Without a bus access or a pending fuse load the trims must not move.
  a_ofs_hold: assert property (@(posedge clk) disable iff (!nrst)
    !req && (st_q.loaded || !fuse_valid)
    |=> st_q.ofs == $past(st_q.ofs))
    else $error("offset trims changed without cause");

  a_gain_hold: assert property (@(posedge clk) disable iff (!nrst)
    !req && (st_q.loaded || !fuse_valid)
    |=> st_q.gain == $past(st_q.gain))
    else $error("gains changed without cause");

  a_fuse_once: assert property (@(posedge clk) disable iff (!nrst)
    st_q.loaded
    |=> st_q.loaded)
    else $error("fuse load flag dropped");

  a_fuse_skip: assert property (@(posedge clk) disable iff (!nrst)
    fuse_valid && !st_q.loaded && st_q.sw_wrote && !req
    |=> st_q.ofs == $past(st_q.ofs))
    else $error("fuse load overwrote software trims");

  // The fuse image must reach the bank gain outputs as well as the registers.
  a_gain_fuse_b1: assert property (@(posedge clk) disable iff (!nrst)
    fuse_valid && !st_q.loaded && !st_q.sw_wrote && !req
    |=> gain_bank1 == $past(fuse_data.gain[1][4:0]))
    else $error("bank1 gain not taken from fuse");

  a_gain_fuse_b4: assert property (@(posedge clk) disable iff (!nrst)
    fuse_valid && !st_q.loaded && !st_q.sw_wrote && !req
    |=> gain_bank4 == $past(fuse_data.gain[2][4:0]))
    else $error("bank4 gain not taken from fuse");

  a_gain_fuse_b5: assert property (@(posedge clk) disable iff (!nrst)
    fuse_valid && !st_q.loaded && !st_q.sw_wrote && !req
    |=> gain_bank5 == $past(fuse_data.gain[3][4:0]))
    else $error("bank5 gain not taken from fuse");

endmodule

// File: tb_ctrb_trim_bank.sv
`timescale 1ns/10ps
module tb_ctrb_trim_bank;
  logic                   clk;
  logic                   nrst;
  logic                   fuse_valid;
  ctrb_pkg::ctrb_fuse_t   fuse_data;
  ctrb_pkg::ctrb_ctx_t    ctx;
  ctrb_pkg::ctrb_wb_req_t wb_req;
  logic [31:0]            wb_dat_o;
  logic                   wb_ack_o;
  logic                   wb_err_o;
  logic [11:0]            ofs_trim;
  logic                   ofs_trim_valid;
  logic [4:0]             gain_bank0;
  logic [4:0]             gain_bank1;
  logic [4:0]             gain_bank4;
  logic [4:0]             gain_bank5;
  logic                   fg_cal_en;
  int                     num_errors;
  int                     comparisons;
  logic [31:0]            rd;
  logic                   er;
  logic [11:0]            idx_tab [8];
  logic [31:0]            fuse_tab [8];
  logic [31:0]            wr_tab [8];

  ctrb_trim_bank ctrb_trim_bank_inst (
    .clk            (clk),
    .nrst           (nrst),
    .fuse_valid     (fuse_valid),
    .fuse_data      (fuse_data),
    .ctx            (ctx),
    .wb_req         (wb_req),
    .wb_dat_o       (wb_dat_o),
    .wb_ack_o       (wb_ack_o),
    .wb_err_o       (wb_err_o),
    .ofs_trim       (ofs_trim),
    .ofs_trim_valid (ofs_trim_valid),
    .gain_bank0     (gain_bank0),
    .gain_bank1     (gain_bank1),
    .gain_bank4     (gain_bank4),
    .gain_bank5     (gain_bank5),
    .fg_cal_en      (fg_cal_en)
  );

  always #2.5 clk = ~clk;

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; ack or err is sampled at the edge, then the request drops.
  task automatic xfer(input logic [11:0] idx, input logic we, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic err);
    int n;
    @(posedge clk);
    wb_req <= '{adr: {18'h0, idx, 2'h0}, dat: wd, sel: 4'hF, we: we, cyc: 1'h1, stb: 1'h1};
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (wb_ack_o === 1'h1 || wb_err_o === 1'h1) break;
    end
    if (n == 50) begin
      num_errors++;
      report_and_stop();
    end
    rdat = wb_dat_o;
    err = wb_err_o;
    wb_req.cyc <= 1'h0;
    wb_req.stb <= 1'h0;
  endtask

  initial begin
    clk = 1'h0;
    nrst = 1'h0;
    fuse_valid = 1'h0;
    fuse_data = '0;
    ctx = '0;
    wb_req = '0;
    num_errors = 0;
    comparisons = 0;
    idx_tab = '{ctrb_pkg::IDX_OFS_C1_P90_IN1, ctrb_pkg::IDX_OFS_C1_P90_IN2,
                ctrb_pkg::IDX_OFS_C2_P0_IN1, ctrb_pkg::IDX_OFS_C2_P0_IN2,
                ctrb_pkg::IDX_BANK0_FINE_GAIN, ctrb_pkg::IDX_BANK1_FINE_GAIN,
                ctrb_pkg::IDX_BANK4_FINE_GAIN, ctrb_pkg::IDX_BANK5_FINE_GAIN};
    fuse_tab = '{32'hA123, 32'hB456, 32'hC789, 32'hDABC, 32'hE1, 32'h52, 32'hB3, 32'h14};
    wr_tab = '{32'hF5A5, 32'h1E0F, 32'h7001, 32'h0FFE, 32'hBF, 32'h60, 32'hFF, 32'hE7};
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    check({31'h0, fg_cal_en}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      fuse_data.ofs[i] <= fuse_tab[i][15:0];
      fuse_data.gain[i] <= fuse_tab[i+4][7:0];
    end
    fuse_valid <= 1'h1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      xfer(idx_tab[i], 1'h0, 32'h0, rd, er);
      check(rd, fuse_tab[i]);
    end
    check({27'h0, gain_bank0}, fuse_tab[4] & 32'h1F);
    check({27'h0, gain_bank5}, fuse_tab[7] & 32'h1F);
    // Calibration is still off, so a matching context must not apply a trim.
    ctx <= '{core2: 1'h0, in2: 1'h0, ph90: 1'h1};
    @(posedge clk);
    @(posedge clk);
    check({31'h0, ofs_trim_valid}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      xfer(idx_tab[i], 1'h1, wr_tab[i], rd, er);
      xfer(idx_tab[i], 1'h0, 32'h0, rd, er);
      check(rd, wr_tab[i]);
    end
    check({27'h0, gain_bank0}, wr_tab[4] & 32'h1F);
    check({27'h0, gain_bank1}, wr_tab[5] & 32'h1F);
    check({27'h0, gain_bank4}, wr_tab[6] & 32'h1F);
    check({27'h0, gain_bank5}, wr_tab[7] & 32'h1F);
    xfer(ctrb_pkg::IDX_CAL_CTRL, 1'h1, 32'h1, rd, er);
    @(posedge clk);
    check({31'h0, fg_cal_en}, 32'h1);
    // Walk all eight contexts; only core1 at 90 and core2 at 0 pick a slot.
    for (int k = 0; k < 8; k++) begin
      ctx <= ctrb_pkg::ctrb_ctx_t'(k[2:0]);
      @(posedge clk);
      @(posedge clk);
      if (k[2] == k[0]) begin
        check({31'h0, ofs_trim_valid}, 32'h0);
      end else begin
        check({31'h0, ofs_trim_valid}, 32'h1);
        check({20'h0, ofs_trim}, wr_tab[2*k[2] + k[1]] & 32'hFFF);
      end
    end
    xfer(ctrb_pkg::IDX_CAL_CTRL, 1'h1, 32'h0, rd, er);
    ctx <= '{core2: 1'h1, in2: 1'h1, ph90: 1'h0};
    repeat (2) @(posedge clk);
    check({31'h0, ofs_trim_valid}, 32'h0);
    xfer(12'h100, 1'h1, 32'h5, rd, er);
    check({31'h0, er}, 32'h1);
    xfer(idx_tab[3], 1'h0, 32'h0, rd, er);
    check(rd, wr_tab[3]);
    report_and_stop();
  end
endmodule
